// [logic/slave_mode_pkg.sv]
package slave_mode_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// register byte addresses
	localparam logic [7:0] SLAVE_MODE_CONTROL_OFFSET = 8'h08;
	localparam logic [7:0] SLAVE_STATUS_OFFSET       = 8'h0C;

	// reset values
	localparam logic [15:0] SLAVE_MODE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] SLAVE_STATUS_RESET       = 16'h0000;

	// slave_mode_control field positions
	localparam int FUNC_LSB  = 0;
	localparam int FUNC_MSB  = 2;
	localparam int TSEL_LSB  = 4;
	localparam int TSEL_MSB  = 6;
	localparam int MSYNC_BIT = 7;

	// slave_status field positions
	localparam int STAT_TRIG_LEVEL = 0;
	localparam int STAT_DOWN       = 1;
	localparam int STAT_GATE_OPEN  = 2;
	localparam int STAT_TRIG_SEEN  = 3;

	// synchroniser depth in flip-flops
	localparam int SYNC_STAGES = 2;

	// slave function codes
	typedef enum logic [2:0] {
		FUNC_OFF       = 3'b000,
		FUNC_ENC_CH2   = 3'b001,
		FUNC_ENC_CH1   = 3'b010,
		FUNC_ENC_BOTH  = 3'b011,
		FUNC_RESET     = 3'b100,
		FUNC_GATED     = 3'b101,
		FUNC_TRIGGER   = 3'b110,
		FUNC_EXT_CLOCK = 3'b111
	} slave_func_t;

	// trigger source codes
	typedef enum logic [2:0] {
		TSRC_INT0    = 3'b000,
		TSRC_INT1    = 3'b001,
		TSRC_INT2    = 3'b010,
		TSRC_INT3    = 3'b011,
		TSRC_CH1_ED  = 3'b100,
		TSRC_CH1_FLT = 3'b101,
		TSRC_CH2_FLT = 3'b110,
		TSRC_EXT_FLT = 3'b111
	} trig_src_t;

	// bit positions inside the synchronised input vector
	localparam int IN_INT    = 0;
	localparam int IN_CH1_ED = 4;
	localparam int IN_CH1    = 5;
	localparam int IN_CH2    = 6;
	localparam int IN_EXT    = 7;
	localparam int IN_W      = 8;

endpackage

// [logic/input_edge_sync.sv]
`timescale 1ns/100ps
module input_edge_sync
#(
	parameter int WIDTH  = 8,
	parameter int STAGES = 2
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// raw inputs
	input  wire logic [WIDTH-1:0] async_i,
	// synchronised level and one-cycle edges
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] stage [STAGES];
	logic [WIDTH-1:0] prev;
	logic [STAGES:0]  warm;

	// the first stage feeds only the next stage, never the edge logic
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < STAGES; i++)
				stage[i] <= '0;
			prev <= '0;
			warm <= '0;
		end
		else
		begin
			stage[0] <= async_i;
			for (int i = 1; i < STAGES; i++)
				stage[i] <= stage[i-1];
			prev <= stage[STAGES-1];
			warm <= {warm[STAGES-1:0], 1'b1};
		end
	end

	assign level_o = stage[STAGES-1];
	// edges wait until the chain has refilled after reset, so a pin idling high
	// gives no false edge; a real edge in those first cycles is lost
	assign rise_o  = stage[STAGES-1] & ~prev & {WIDTH{warm[STAGES]}};
	assign fall_o  = ~stage[STAGES-1] & prev & {WIDTH{warm[STAGES]}};

endmodule

// [logic/slave_mode_ctrl.sv]
`timescale 1ns/100ps
module slave_mode_ctrl
(
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_n_i,
	// register port
	input  wire logic [slave_mode_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [slave_mode_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                              wr_i,
	input  wire logic                              rd_i,
	output logic      [slave_mode_pkg::DATA_W-1:0] rdata_o,
	// trigger and channel inputs
	input  wire logic [3:0]                        internal_trigger_i,
	input  wire logic                              ch1_edge_detect_i,
	input  wire logic                              ch1_filtered_input_i,
	input  wire logic                              ch2_filtered_input_i,
	input  wire logic                              ext_trigger_filtered_i,
	// counter state from the timer core
	input  wire logic                              counter_run_enable_i,
	// counter controls
	output logic                                   count_tick_o,
	output logic                                   count_down_o,
	output logic                                   counter_reset_o,
	output logic                                   update_event_o,
	output logic                                   counter_start_o,
	output logic                                   selected_trigger_input_o,
	output logic                                   master_slave_sync_enable_o
);

	// register state
	logic [slave_mode_pkg::DATA_W-1:0] slave_mode_control;
	logic [slave_mode_pkg::DATA_W-1:0] next_slave_mode_control;
	logic [slave_mode_pkg::DATA_W-1:0] next_rdata;

	// synchronised inputs
	logic [slave_mode_pkg::IN_W-1:0] in_raw;
	logic [slave_mode_pkg::IN_W-1:0] in_level;
	logic [slave_mode_pkg::IN_W-1:0] in_rise;
	logic [slave_mode_pkg::IN_W-1:0] in_fall;

	// decoded control
	slave_mode_pkg::slave_func_t func;
	logic [2:0]                  trig_sel;
	logic                        trig_level;
	logic                        trig_rise;
	logic                        ch1_edge;
	logic                        ch2_edge;
	logic                        ch1;
	logic                        ch2;

	// output and status state
	logic count_tick;
	logic count_down;
	logic counter_reset;
	logic update_event;
	logic counter_start;
	logic trig_out;
	logic msync;
	logic trig_seen;
	logic next_count_tick;
	logic next_count_down;
	logic next_counter_reset;
	logic next_update_event;
	logic next_counter_start;
	logic next_trig_out;
	logic next_msync;
	logic next_trig_seen;

	// picks one trigger source out of a vector of levels or edges
	function automatic logic select_trigger(input logic [2:0] sel,
		input logic [slave_mode_pkg::IN_W-1:0] vec);
		logic result;
		result = 1'b0;
		case (sel)
			slave_mode_pkg::TSRC_INT0:    result = vec[slave_mode_pkg::IN_INT];
			slave_mode_pkg::TSRC_INT1:    result = vec[slave_mode_pkg::IN_INT + 1];
			slave_mode_pkg::TSRC_INT2:    result = vec[slave_mode_pkg::IN_INT + 2];
			slave_mode_pkg::TSRC_INT3:    result = vec[slave_mode_pkg::IN_INT + 3];
			slave_mode_pkg::TSRC_CH1_ED:  result = vec[slave_mode_pkg::IN_CH1_ED];
			slave_mode_pkg::TSRC_CH1_FLT: result = vec[slave_mode_pkg::IN_CH1];
			slave_mode_pkg::TSRC_CH2_FLT: result = vec[slave_mode_pkg::IN_CH2];
			slave_mode_pkg::TSRC_EXT_FLT: result = vec[slave_mode_pkg::IN_EXT];
			default:                      result = 1'b0;
		endcase
		return result;
	endfunction

	assign in_raw = {ext_trigger_filtered_i, ch2_filtered_input_i, ch1_filtered_input_i,
		ch1_edge_detect_i, internal_trigger_i};

	input_edge_sync
	#(
		.WIDTH  (slave_mode_pkg::IN_W),
		.STAGES (slave_mode_pkg::SYNC_STAGES)
	)
	u_sync
	(
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (in_raw),
		.level_o (in_level),
		.rise_o  (in_rise),
		.fall_o  (in_fall)
	);

	assign func     = slave_mode_pkg::slave_func_t'(
		slave_mode_control[slave_mode_pkg::FUNC_MSB:slave_mode_pkg::FUNC_LSB]);
	assign trig_sel = slave_mode_control[slave_mode_pkg::TSEL_MSB:slave_mode_pkg::TSEL_LSB];

	// edges are taken per source, so a source change alone makes no edge; a level
	// difference between old and new source can still flip the gate in gated mode
	assign trig_level = select_trigger(trig_sel, in_level);
	assign trig_rise  = select_trigger(trig_sel, in_rise);
	assign ch1        = in_level[slave_mode_pkg::IN_CH1];
	assign ch2        = in_level[slave_mode_pkg::IN_CH2];
	assign ch1_edge   = in_rise[slave_mode_pkg::IN_CH1] | in_fall[slave_mode_pkg::IN_CH1];
	assign ch2_edge   = in_rise[slave_mode_pkg::IN_CH2] | in_fall[slave_mode_pkg::IN_CH2];

	// register write and read
	always_comb
	begin
		next_slave_mode_control = slave_mode_control;
		next_rdata              = '0;
		if (wr_i && addr_i == slave_mode_pkg::SLAVE_MODE_CONTROL_OFFSET)
		begin
			// only bits 7:0 are held; bit 3 is reserved and reads zero
			next_slave_mode_control                                      = '0;
			next_slave_mode_control[slave_mode_pkg::FUNC_MSB:slave_mode_pkg::FUNC_LSB] =
				wdata_i[slave_mode_pkg::FUNC_MSB:slave_mode_pkg::FUNC_LSB];
			next_slave_mode_control[slave_mode_pkg::TSEL_MSB:slave_mode_pkg::TSEL_LSB] =
				wdata_i[slave_mode_pkg::TSEL_MSB:slave_mode_pkg::TSEL_LSB];
			next_slave_mode_control[slave_mode_pkg::MSYNC_BIT] =
				wdata_i[slave_mode_pkg::MSYNC_BIT];
		end
		if (rd_i)
		begin
			case (addr_i)
				slave_mode_pkg::SLAVE_MODE_CONTROL_OFFSET:
				begin
					next_rdata = slave_mode_control;
				end
				slave_mode_pkg::SLAVE_STATUS_OFFSET:
				begin
					next_rdata[slave_mode_pkg::STAT_TRIG_LEVEL] = trig_level;
					next_rdata[slave_mode_pkg::STAT_DOWN]       = count_down;
					next_rdata[slave_mode_pkg::STAT_GATE_OPEN]  = ~trig_level;
					next_rdata[slave_mode_pkg::STAT_TRIG_SEEN]  = trig_seen;
				end
				default:
				begin
					next_rdata = '0;
				end
			endcase
		end
	end

	// counter control per slave function
	always_comb
	begin
		next_count_tick    = 1'b0;
		next_count_down    = count_down;
		next_counter_reset = 1'b0;
		next_update_event  = 1'b0;
		next_counter_start = 1'b0;
		next_trig_out      = trig_level;
		next_msync         = slave_mode_control[slave_mode_pkg::MSYNC_BIT];
		next_trig_seen     = trig_seen | trig_rise;
		case (func)
			slave_mode_pkg::FUNC_OFF:
			begin
				next_count_tick = counter_run_enable_i;
				// function off clears the flag, but an edge in the same cycle wins
				next_trig_seen  = trig_rise;
			end
			slave_mode_pkg::FUNC_ENC_CH2:
			begin
				next_count_tick = counter_run_enable_i & ch2_edge;
				if (ch2_edge)
					next_count_down = ch1 ^ ch2;
			end
			slave_mode_pkg::FUNC_ENC_CH1:
			begin
				next_count_tick = counter_run_enable_i & ch1_edge;
				if (ch1_edge)
					next_count_down = ~(ch1 ^ ch2);
			end
			slave_mode_pkg::FUNC_ENC_BOTH:
			begin
				// a simultaneous edge on both is a glitch and is not counted
				next_count_tick = counter_run_enable_i & (ch1_edge ^ ch2_edge);
				if (ch1_edge && !ch2_edge)
					next_count_down = ~(ch1 ^ ch2);
				else if (ch2_edge && !ch1_edge)
					next_count_down = ch1 ^ ch2;
			end
			slave_mode_pkg::FUNC_RESET:
			begin
				next_count_tick    = counter_run_enable_i & ~trig_rise;
				next_counter_reset = trig_rise;
				next_update_event  = trig_rise;
			end
			slave_mode_pkg::FUNC_GATED:
			begin
				// gate only stalls ticks; counter_reset stays low here
				next_count_tick = counter_run_enable_i & ~trig_level;
			end
			slave_mode_pkg::FUNC_TRIGGER:
			begin
				next_counter_start = trig_rise & ~counter_run_enable_i;
				next_count_tick    = counter_run_enable_i;
			end
			slave_mode_pkg::FUNC_EXT_CLOCK:
			begin
				next_count_tick = counter_run_enable_i & trig_rise;
			end
			default:
			begin
				next_count_tick = 1'b0;
			end
		endcase
		if (func != slave_mode_pkg::FUNC_ENC_CH2 && func != slave_mode_pkg::FUNC_ENC_CH1
			&& func != slave_mode_pkg::FUNC_ENC_BOTH)
			next_count_down = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			slave_mode_control <= slave_mode_pkg::SLAVE_MODE_CONTROL_RESET;
			rdata_o            <= '0;
			count_tick         <= 1'b0;
			count_down         <= 1'b0;
			counter_reset      <= 1'b0;
			update_event       <= 1'b0;
			counter_start      <= 1'b0;
			trig_out           <= 1'b0;
			msync              <= 1'b0;
			trig_seen          <= 1'b0;
		end
		else
		begin
			slave_mode_control <= next_slave_mode_control;
			rdata_o            <= next_rdata;
			count_tick         <= next_count_tick;
			count_down         <= next_count_down;
			counter_reset      <= next_counter_reset;
			update_event       <= next_update_event;
			counter_start      <= next_counter_start;
			trig_out           <= next_trig_out;
			msync              <= next_msync;
			trig_seen          <= next_trig_seen;
		end
	end

	assign count_tick_o               = count_tick;
	assign count_down_o               = count_down;
	assign counter_reset_o            = counter_reset;
	assign update_event_o             = update_event;
	assign counter_start_o            = counter_start;
	assign selected_trigger_input_o   = trig_out;
	assign master_slave_sync_enable_o = msync;

endmodule

// [testbench/slave_mode_props.sv]
`timescale 1ns/100ps
module slave_mode_props
(
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_n_i,
	// register port
	input  wire logic [slave_mode_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [slave_mode_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                              wr_i,
	input  wire logic                              rd_i,
	input  wire logic [slave_mode_pkg::DATA_W-1:0] rdata_o,
	// counter side
	input  wire logic                              counter_run_enable_i,
	input  wire logic                              count_tick_o,
	input  wire logic                              count_down_o,
	input  wire logic                              counter_reset_o,
	input  wire logic                              update_event_o,
	input  wire logic                              counter_start_o,
	input  wire logic                              selected_trigger_input_o,
	input  wire logic                              master_slave_sync_enable_o
);
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic [2:0]  func;

	// shadow of the control register, bits 15:8 and 3 are not held
	always_comb
	begin
		next_ctrl = ctrl;
		if (wr_i && addr_i == 8'h08)
			next_ctrl = wdata_i & 16'h00F7;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ctrl <= 16'h0000;
		else
			ctrl <= next_ctrl;
	end
	assign func = ctrl[2:0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rdata_ctrl: assert property ($past(rd_i && addr_i == 8'h08) |->
		rdata_o == $past(ctrl))
		else $error("control read back differs");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside read cycle");
	a_sync_copy: assert property (master_slave_sync_enable_o == $past(ctrl[7]))
		else $error("sync enable does not follow bit 7");
	a_off_quiet: assert property ((func == 3'b000 && $past(func) == 3'b000)
		|-> !counter_reset_o && !counter_start_o && !update_event_o)
		else $error("slave action while function off");
	a_reset_cause: assert property (counter_reset_o
		|-> update_event_o && $past(func) == 3'b100)
		else $error("counter reset without reset mode or update");
	a_reset_single: assert property (counter_reset_o |=> !counter_reset_o)
		else $error("counter reset longer than one cycle");
	a_start_cause: assert property (counter_start_o
		|-> $past(func) == 3'b110 && !$past(counter_run_enable_i))
		else $error("start outside trigger mode");
	a_gate_low: assert property (func == 3'b101 && $past(func) == 3'b101
		&& count_tick_o |-> !selected_trigger_input_o)
		else $error("gated tick with trigger high");
	a_ext_edge: assert property (func == 3'b111 && $past(func) == 3'b111
		&& count_tick_o |-> $rose(selected_trigger_input_o))
		else $error("external clock tick without trigger rise");
	a_down_idle: assert property ((func[2] && $past(func[2])) |-> !count_down_o)
		else $error("direction set outside encoder modes");

	c_reset_seen: cover property (counter_reset_o);
	c_start_seen: cover property (counter_start_o);
	c_down_tick: cover property (count_tick_o && count_down_o);
endmodule

bind slave_mode_ctrl slave_mode_props props_u
(
	.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .counter_run_enable_i(counter_run_enable_i),
	.count_tick_o(count_tick_o), .count_down_o(count_down_o),
	.counter_reset_o(counter_reset_o), .update_event_o(update_event_o),
	.counter_start_o(counter_start_o), .selected_trigger_input_o(selected_trigger_input_o),
	.master_slave_sync_enable_o(master_slave_sync_enable_o)
);

// [testbench/trigger_source_model.sv]
`timescale 1ns/100ps
module trigger_source_model
(
	// requests from the bench
	input  wire logic       clk_i,
	input  wire logic [2:0] src_i,
	input  wire logic       level_i,
	input  wire logic       ch1_i,
	input  wire logic       ch2_i,
	// far-side lines
	output logic [3:0]      internal_trigger_o,
	output logic            ch1_edge_detect_o,
	output logic            ch1_filtered_o,
	output logic            ch2_filtered_o,
	output logic            ext_trigger_filtered_o
);
	logic [7:0] lines;
	logic [7:0] next_lines;

	// only the chosen source and the ch1/ch2 lines move, so no other line can fake an edge
	always_comb
	begin
		next_lines = 8'h00;
		next_lines[src_i] = level_i;
		next_lines[5] = next_lines[5] | ch1_i;
		next_lines[6] = next_lines[6] | ch2_i;
	end
	// master timers change on their clock edge and hold whole cycles
	always_ff @(posedge clk_i)
		lines <= next_lines;
	assign internal_trigger_o = lines[3:0];
	assign ch1_edge_detect_o = lines[4];
	assign ch1_filtered_o = lines[5];
	assign ch2_filtered_o = lines[6];
	assign ext_trigger_filtered_o = lines[7];
endmodule

// [testbench/slave_mode_ctrl_tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module slave_mode_ctrl_tb;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, run_en = 0, lvl = 0, c1 = 0, c2 = 0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [2:0]  src = 3'h0;
	logic [3:0]  itr;
	logic        ced, cf1, cf2, etf, tick, down, crst, upd, start, trig, msync;
	int          errors = 0, n_tests = 0;

	always #4 clk = ~clk;

	trigger_source_model src_u (.clk_i(clk), .src_i(src), .level_i(lvl), .ch1_i(c1),
		.ch2_i(c2), .internal_trigger_o(itr), .ch1_edge_detect_o(ced), .ch1_filtered_o(cf1),
		.ch2_filtered_o(cf2), .ext_trigger_filtered_o(etf));
	slave_mode_ctrl dut_u (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .internal_trigger_i(itr),
		.ch1_edge_detect_i(ced), .ch1_filtered_input_i(cf1), .ch2_filtered_input_i(cf2),
		.ext_trigger_filtered_i(etf), .counter_run_enable_i(run_en), .count_tick_o(tick),
		.count_down_o(down), .counter_reset_o(crst), .update_event_o(upd),
		.counter_start_o(start), .selected_trigger_input_o(trig),
		.master_slave_sync_enable_o(msync));

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	// the function is turned off first and the trigger select moves while off; the model source follows once the function is set
	task automatic mode(input logic [2:0] s, input logic [2:0] f);
		wr_reg(8'h08, {9'h000, src, 4'h0});
		wr_reg(8'h08, {9'h000, s, 4'h0});
		wr_reg(8'h08, {9'h000, s, 1'b0, f});
		src <= s;
	endtask
	// one model cycle plus three through the synchroniser and output flop
	task automatic drive(input logic l);
		@(posedge clk);
		lvl <= l;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic next_cycle;
		@(posedge clk);
		#1;
	endtask

	task automatic t_regs;
		rd_chk(8'h08, 16'h0000);
		wr_reg(8'h08, 16'hFFFF);
		rd_chk(8'h08, 16'h00F7);
		`CHK(msync, 1'b1)
		wr_reg(8'h10, 16'h1234);
		rd_chk(8'h10, 16'h0000);
		rd_chk(8'h08, 16'h00F7);
		wr_reg(8'h08, 16'h0070);
		next_cycle();
		`CHK(msync, 1'b0)
	endtask
	task automatic t_sources;
		for (int s = 0; s < 8; s++)
		begin
			mode(s[2:0], 3'b100);
			drive(1'b1);
			`CHK({crst, upd}, 2'b11)
			`CHK(trig, 1'b1)
			next_cycle();
			`CHK({crst, upd}, 2'b00)
			drive(1'b0);
			`CHK(crst, 1'b0)
			`CHK(trig, 1'b0)
		end
	endtask
	task automatic t_modes;
		@(posedge clk);
		run_en <= 1'b1;
		mode(3'h0, 3'b000);
		drive(1'b1);
		`CHK({crst, tick}, 2'b01)
		drive(1'b0);
		mode(3'h0, 3'b111);
		drive(1'b1);
		`CHK(tick, 1'b1)
		next_cycle();
		`CHK(tick, 1'b0)
		drive(1'b0);
		`CHK(tick, 1'b0)
		mode(3'h0, 3'b101);
		repeat (4) next_cycle();
		`CHK(tick, 1'b1)
		drive(1'b1);
		`CHK({crst, tick}, 2'b00)
		rd_chk(8'h0C, 16'h0009);
		drive(1'b0);
		`CHK(tick, 1'b1)
		@(posedge clk);
		run_en <= 1'b0;
		mode(3'h0, 3'b110);
		drive(1'b1);
		`CHK(start, 1'b1)
		next_cycle();
		`CHK(start, 1'b0)
		drive(1'b0);
	endtask
	task automatic enc_step(input logic ch, input logic v, input logic dn, input int f);
		@(posedge clk);
		if (ch)
			c2 <= v;
		else
			c1 <= v;
		repeat (4) @(posedge clk);
		#1;
		`CHK(tick, (ch ? f != 2 : f != 1))
		if (tick === 1'b1)
			`CHK(down, dn)
	endtask
	task automatic t_encoder;
		@(posedge clk);
		run_en <= 1'b1;
		for (int f = 1; f < 4; f++)
		begin
			mode(3'h0, f[2:0]);
			enc_step(1'b1, 1'b1, 1'b1, f);
			enc_step(1'b1, 1'b0, 1'b0, f);
			enc_step(1'b0, 1'b1, 1'b0, f);
			enc_step(1'b0, 1'b0, 1'b1, f);
		end
	endtask

	task automatic wrap_up;
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_sources();
		t_modes();
		t_encoder();
		wrap_up();
	end
endmodule
